// >>> rtl/afz_consts.svh
`ifndef AFZ_CONSTS_SVH
`define AFZ_CONSTS_SVH

// Register indices on the plain register port.
`define AFZ_REG_CTRL 4'h0
`define AFZ_REG_ZONE_LIGHT 4'h1
`define AFZ_REG_ZONE_CURR 4'h2
`define AFZ_REG_SENSOR_CFG 4'h3
`define AFZ_REG_PH_LIMIT 4'h4
`define AFZ_REG_RES_LIMIT 4'h5
`define AFZ_REG_SAMPLE_REQ 4'h6
`define AFZ_REG_STATUS 4'h7

// Field positions of the control register.
`define AFZ_CTRL_ZONE_EN_LSB 0
`define AFZ_CTRL_TEST_PULSE 4
`define AFZ_CTRL_RES_SEL_LSB 5

// Field positions of the current enable and sensor setting registers.
`define AFZ_CURR_RES_EN_LSB 4
`define AFZ_CFG_UNIT_LSB 8

// Field positions of the status register.
`define AFZ_ST_LIGHT_LSB 0
`define AFZ_ST_SFAULT_LSB 4
`define AFZ_ST_TRIP_LSB 8
`define AFZ_ST_BLK_LSB 12
`define AFZ_ST_PH_START 16
`define AFZ_ST_RES_START 17
`define AFZ_ST_PH_BLK 18
`define AFZ_ST_RES_BLK 19
`define AFZ_ST_ARC_BI 20
`define AFZ_ST_UNIT_FAULT 21

// Reset values.
`define AFZ_RST_ZONE_EN 4'h0
`define AFZ_RST_ZONE_LIGHT 16'h0000
`define AFZ_RST_ZONE_CURR 4'h0
`define AFZ_RST_SENSOR_CFG 8'h00
`define AFZ_RST_UNIT_CFG 4'h0
`define AFZ_RST_LIMIT 16'h0078
`define AFZ_RST_SAMPLE_REQ 4'h1

// Timing.
`define AFZ_CLK_PERIOD_NS 50
`define AFZ_TIME_BASE_MS 5
`define AFZ_TIME_BASE_CYC (`AFZ_TIME_BASE_MS * 1000000 / `AFZ_CLK_PERIOD_NS)
`define AFZ_BI_FILTER_US 1000
`define AFZ_BI_FILTER_CYC (`AFZ_BI_FILTER_US * 1000 / `AFZ_CLK_PERIOD_NS)

`endif

// >>> rtl/afz_pkg.sv
package afz_pkg;

  typedef enum logic [1:0] {
    AFZ_RES_NONE = 2'h0,
    AFZ_RES_ONE = 2'h1,
    AFZ_RES_TWO = 2'h2
  } afz_ressel_t;

  typedef enum logic [1:0] {
    AFZ_BI_IDLE = 2'h0,
    AFZ_BI_QUAL = 2'h1,
    AFZ_BI_ON = 2'h3
  } afz_bi_state_t;

endpackage

// >>> rtl/afz_sync.sv
`timescale 1ns/1ps
`default_nettype none

module afz_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Levels from outside and their synchronised copies.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

`default_nettype wire

// >>> rtl/afz_curr_qual.sv
`timescale 1ns/1ps
`default_nettype none

module afz_curr_qual #(
  parameter int SW = 16,
  parameter int CW = 4
) (
  // Clock, reset and the sample time base.
  input wire logic clock,
  input wire logic nrst,
  input wire logic tick,
  // Sample, limit and required count.
  input wire logic [SW-1:0] sample,
  input wire logic [SW-1:0] limit,
  input wire logic [CW-1:0] need,
  // Current condition.
  output logic over
);
  logic [CW-1:0] hits;
  wire above = sample > limit;
  wire at_max = &hits;

  // Counts consecutive samples above the limit, restarting on any low one.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hits <= '0;
    end else if (tick) begin
      if (!above) begin
        hits <= '0;
      end else if (!at_max) begin
        hits <= hits + 1'b1;
      end
    end
  end

  assign over = (hits != '0) && (hits >= need);
endmodule

`default_nettype wire

// >>> rtl/afz_trip_logic.sv
// How it works
// - Four sensor channels, up to three sensors.
// - Current-qualified zone needs light and current.
// - Light output per channel while light seen.
// - Binary input output follows energised input.
// - Phase and residual start above limits.
// - Blocking input gives current blocked outputs.
// - Zone trips when its conditions are met.
// - Blocked zone reports blocked, not trip.
// - Sensor fault on channel count mismatch.
// - Unit fault on unit count mismatch.
// - Test pulse option filters binary input.
// - Enabled current must exceed its limit.
// - Current needs required number of samples.
// - Five current streams on 5 ms base.
// - Per-zone light channel enables.
// - Phase and residual enabled per zone.
// - Fast outputs skip the output stage.
// - Zone enables reset off; disabled never trips.
// - Residual source none, first or second.
// - Sensor counts zero to three, default zero.
`include "afz_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module afz_trip_logic #(
  parameter int SW = 16,
  parameter int CW = 4,
  parameter int TICK_CYCLES = `AFZ_TIME_BASE_CYC,
  parameter int BI_FILTER_CYCLES = `AFZ_BI_FILTER_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Arc card pins.
  input wire logic [3:0] light_pin,
  input wire logic arc_bi_pin,
  input wire logic [7:0] sensor_seen_pin,
  input wire logic [3:0] unit_seen_pin,
  // Current samples.
  input wire logic [SW-1:0] phase_current_a,
  input wire logic [SW-1:0] phase_current_b,
  input wire logic [SW-1:0] phase_current_c,
  input wire logic [SW-1:0] residual_input_one,
  input wire logic [SW-1:0] residual_input_two,
  // Blocking inputs.
  input wire logic block_phase,
  input wire logic block_residual,
  input wire logic [3:0] block_zone,
  // Status outputs.
  output logic [3:0] light_detected,
  output logic arc_binary_input_1,
  output logic phase_start,
  output logic residual_start,
  output logic phase_blocked,
  output logic residual_blocked,
  output logic [3:0] zone_trip,
  output logic [3:0] zone_blocked,
  output logic [3:0] sensor_fault,
  output logic unit_fault,
  // Fast outputs.
  output logic fast_output_1,
  output logic fast_output_2
);
  import afz_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int FW = $clog2(BI_FILTER_CYCLES + 1);

  // Settings.
  logic [3:0] zone_en;
  logic test_pulse_en;
  afz_ressel_t res_sel;
  logic [15:0] zone_light;
  logic [3:0] zone_ph_en;
  logic [3:0] zone_res_en;
  logic [7:0] sensor_cfg;
  logic [3:0] unit_cfg;
  logic [SW-1:0] ph_limit;
  logic [SW-1:0] res_limit;
  logic [CW-1:0] sample_req;

  // Synchronised pins.
  logic [3:0] light_sync;
  logic bi_sync;
  logic [7:0] sensor_seen;
  logic [3:0] unit_seen;

  afz_sync #(.WIDTH(17)) u_pins (
    .clock(clock),
    .nrst(nrst),
    .async_in({unit_seen_pin, sensor_seen_pin, arc_bi_pin, light_pin}),
    .sync_out({unit_seen, sensor_seen, bi_sync, light_sync})
  );

  // Register decode.
  wire wr_ctrl = reg_wr && (reg_addr == `AFZ_REG_CTRL);
  wire wr_light = reg_wr && (reg_addr == `AFZ_REG_ZONE_LIGHT);
  wire wr_curr = reg_wr && (reg_addr == `AFZ_REG_ZONE_CURR);
  wire wr_cfg = reg_wr && (reg_addr == `AFZ_REG_SENSOR_CFG);
  wire wr_ph = reg_wr && (reg_addr == `AFZ_REG_PH_LIMIT);
  wire wr_res = reg_wr && (reg_addr == `AFZ_REG_RES_LIMIT);
  wire wr_req = reg_wr && (reg_addr == `AFZ_REG_SAMPLE_REQ);
  wire [1:0] wr_sel = reg_wdata[`AFZ_CTRL_RES_SEL_LSB +: 2];
  wire afz_ressel_t next_res_sel = (wr_sel == AFZ_RES_TWO) ? AFZ_RES_TWO :
                                   (wr_sel == AFZ_RES_ONE) ? AFZ_RES_ONE : AFZ_RES_NONE;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      zone_en <= `AFZ_RST_ZONE_EN;
      test_pulse_en <= 1'b0;
      res_sel <= AFZ_RES_NONE;
      zone_light <= `AFZ_RST_ZONE_LIGHT;
      zone_ph_en <= `AFZ_RST_ZONE_CURR;
      zone_res_en <= `AFZ_RST_ZONE_CURR;
      sensor_cfg <= `AFZ_RST_SENSOR_CFG;
      unit_cfg <= `AFZ_RST_UNIT_CFG;
      ph_limit <= SW'(`AFZ_RST_LIMIT);
      res_limit <= SW'(`AFZ_RST_LIMIT);
      sample_req <= CW'(`AFZ_RST_SAMPLE_REQ);
    end else begin
      if (wr_ctrl) begin
        zone_en <= reg_wdata[`AFZ_CTRL_ZONE_EN_LSB +: 4];
        test_pulse_en <= reg_wdata[`AFZ_CTRL_TEST_PULSE];
        res_sel <= next_res_sel;
      end
      if (wr_light) begin
        zone_light <= reg_wdata[15:0];
      end
      if (wr_curr) begin
        zone_ph_en <= reg_wdata[3:0];
        zone_res_en <= reg_wdata[`AFZ_CURR_RES_EN_LSB +: 4];
      end
      if (wr_cfg) begin
        sensor_cfg <= reg_wdata[7:0];
        unit_cfg <= reg_wdata[`AFZ_CFG_UNIT_LSB +: 4];
      end
      if (wr_ph) begin
        ph_limit <= reg_wdata[SW-1:0];
      end
      if (wr_res) begin
        res_limit <= reg_wdata[SW-1:0];
      end
      if (wr_req) begin
        sample_req <= reg_wdata[CW-1:0];
      end
    end
  end

  // Sample time base.
  logic [TW-1:0] tick_cnt;
  logic tick;
  wire tick_wrap = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
      tick <= tick_wrap;
    end
  end

  // Current conditions for the three phase and two residual streams.
  wire [SW-1:0] stream [5];
  logic [4:0] stream_over;
  assign stream[0] = phase_current_a;
  assign stream[1] = phase_current_b;
  assign stream[2] = phase_current_c;
  assign stream[3] = residual_input_one;
  assign stream[4] = residual_input_two;

  for (genvar s = 0; s < 5; s++) begin : g_stream
    afz_curr_qual #(.SW(SW), .CW(CW)) u_qual (
      .clock(clock),
      .nrst(nrst),
      .tick(tick),
      .sample(stream[s]),
      .limit((s < 3) ? ph_limit : res_limit),
      .need(sample_req),
      .over(stream_over[s])
    );
  end

  wire ph_over = |stream_over[2:0];
  wire res_over = (res_sel == AFZ_RES_ONE) ? stream_over[3] :
                  (res_sel == AFZ_RES_TWO) ? stream_over[4] : 1'b0;
  wire ph_start_c = ph_over && !block_phase;
  wire res_start_c = res_over && !block_residual;
  wire ph_blk_c = ph_over && block_phase;
  wire res_blk_c = res_over && block_residual;

  // Zone decisions.
  logic [3:0] zone_met;
  for (genvar z = 0; z < 4; z++) begin : g_zone
    wire light_ok = |(light_sync & zone_light[4*z +: 4]);
    wire ph_ok = !zone_ph_en[z] || ph_start_c;
    wire res_ok = !zone_res_en[z] || res_start_c;
    assign zone_met[z] = zone_en[z] && light_ok && ph_ok && res_ok;
  end
  wire [3:0] trip_c = zone_met & ~block_zone;
  wire [3:0] blk_c = zone_met & block_zone;

  // Sensor and unit supervision, one channel per two-bit count.
  logic [3:0] sfault_c;
  for (genvar c = 0; c < 4; c++) begin : g_chan
    assign sfault_c[c] = sensor_seen[2*c +: 2] != sensor_cfg[2*c +: 2];
  end
  wire ufault_c = unit_seen != unit_cfg;

  // Binary input qualifier that rejects wiring test pulses.
  afz_bi_state_t bi_state;
  afz_bi_state_t next_bi_state;
  logic [FW-1:0] bi_cnt;
  wire bi_done = bi_cnt == FW'(BI_FILTER_CYCLES - 1);

  always_comb begin
    next_bi_state = bi_state;
    unique case (bi_state)
      AFZ_BI_IDLE: begin
        if (bi_sync) begin
          next_bi_state = test_pulse_en ? AFZ_BI_QUAL : AFZ_BI_ON;
        end
      end
      AFZ_BI_QUAL: begin
        if (!bi_sync) begin
          next_bi_state = AFZ_BI_IDLE;
        end else if (bi_done) begin
          next_bi_state = AFZ_BI_ON;
        end
      end
      AFZ_BI_ON: begin
        if (!bi_sync) begin
          next_bi_state = AFZ_BI_IDLE;
        end
      end
      default: begin
        next_bi_state = AFZ_BI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      bi_state <= AFZ_BI_IDLE;
      bi_cnt <= '0;
    end else begin
      bi_state <= next_bi_state;
      bi_cnt <= (next_bi_state == AFZ_BI_QUAL) ? bi_cnt + 1'b1 : '0;
    end
  end

  // Fast path registered once, ordinary zone outputs one stage later.
  logic [3:0] trip_q;
  logic [3:0] blk_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      fast_output_1 <= 1'b0;
      fast_output_2 <= 1'b0;
      trip_q <= '0;
      blk_q <= '0;
      zone_trip <= '0;
      zone_blocked <= '0;
    end else begin
      fast_output_1 <= |trip_c;
      fast_output_2 <= ph_start_c || res_start_c;
      trip_q <= trip_c;
      blk_q <= blk_c;
      zone_trip <= trip_q;
      zone_blocked <= blk_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      light_detected <= '0;
      arc_binary_input_1 <= 1'b0;
      phase_start <= 1'b0;
      residual_start <= 1'b0;
      phase_blocked <= 1'b0;
      residual_blocked <= 1'b0;
      sensor_fault <= '0;
      unit_fault <= 1'b0;
    end else begin
      light_detected <= light_sync;
      arc_binary_input_1 <= bi_sync && (next_bi_state == AFZ_BI_ON);
      phase_start <= ph_start_c;
      residual_start <= res_start_c;
      phase_blocked <= ph_blk_c;
      residual_blocked <= res_blk_c;
      sensor_fault <= sfault_c;
      unit_fault <= ufault_c;
    end
  end

  // Read port; unmapped indices read zero.
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[`AFZ_ST_LIGHT_LSB +: 4] = light_detected;
    status_word[`AFZ_ST_SFAULT_LSB +: 4] = sensor_fault;
    status_word[`AFZ_ST_TRIP_LSB +: 4] = zone_trip;
    status_word[`AFZ_ST_BLK_LSB +: 4] = zone_blocked;
    status_word[`AFZ_ST_PH_START] = phase_start;
    status_word[`AFZ_ST_RES_START] = residual_start;
    status_word[`AFZ_ST_PH_BLK] = phase_blocked;
    status_word[`AFZ_ST_RES_BLK] = residual_blocked;
    status_word[`AFZ_ST_ARC_BI] = arc_binary_input_1;
    status_word[`AFZ_ST_UNIT_FAULT] = unit_fault;
  end

  wire [31:0] ctrl_word = {25'h0, res_sel, test_pulse_en, zone_en};
  wire [31:0] read_mux =
    (reg_addr == `AFZ_REG_CTRL) ? ctrl_word :
    (reg_addr == `AFZ_REG_ZONE_LIGHT) ? {16'h0000, zone_light} :
    (reg_addr == `AFZ_REG_ZONE_CURR) ? {24'h000000, zone_res_en, zone_ph_en} :
    (reg_addr == `AFZ_REG_SENSOR_CFG) ? {20'h00000, unit_cfg, sensor_cfg} :
    (reg_addr == `AFZ_REG_PH_LIMIT) ? 32'(ph_limit) :
    (reg_addr == `AFZ_REG_RES_LIMIT) ? 32'(res_limit) :
    (reg_addr == `AFZ_REG_SAMPLE_REQ) ? 32'(sample_req) :
    (reg_addr == `AFZ_REG_STATUS) ? status_word : 32'h00000000;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 32'h00000000;
    end
  end

  // Checks.
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  a_zone_disabled:
    assert property (zone_trip[0] |-> $past(zone_en[0], 2))
    else $error("Disabled zone tripped.");
  a_zone_blk_cause:
    assert property (zone_blocked[0] |-> $past(block_zone[0], 2) && !zone_trip[0])
    else $error("Zone blocked without a block input.");
  a_zone_light_or:
    assert property (zone_trip[0] |-> $past(|(light_sync & zone_light[3:0]), 2))
    else $error("Zone tripped without enabled light.");
  a_zone_curr_gate:
    assert property (zone_trip[0] && $past(zone_ph_en[0], 2) |-> $past(ph_start_c, 2))
    else $error("Current-qualified zone tripped without current.");
  a_phase_start:
    assert property (phase_start |-> $past(ph_over) && !$past(block_phase))
    else $error("Phase start without overcurrent.");
  a_phase_blocked:
    assert property (phase_blocked |-> $past(block_phase) && !phase_start)
    else $error("Phase blocked without block input.");
  a_sensor_fault:
    assert property (sensor_fault[1] == $past(sensor_seen[3:2] != sensor_cfg[3:2]))
    else $error("Sensor fault disagrees with counts.");
  a_unit_fault:
    assert property (unit_fault |-> $past(unit_seen != unit_cfg))
    else $error("Unit fault without mismatch.");
  a_bi_filter:
    assert property ($rose(arc_binary_input_1) && $past(test_pulse_en) |-> $past(bi_sync, 2))
    else $error("Short test pulse reached binary input.");
  a_fast_first:
    assert property ($rose(zone_trip[0]) |-> fast_output_1 || $past(fast_output_1))
    else $error("Fast output did not lead zone trip.");
  a_tick_spacing:
    assert property (tick |=> !tick)
    else $error("Time base ticks back to back.");
endmodule

`default_nettype wire

// >>> verif/afz_arc_units_model.sv
`timescale 1ns/1ps
`default_nettype none

module afz_arc_units_model #(
  parameter int PULSE_GAP = 40
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Conditions commanded by the bench.
  input wire logic [3:0] light_on,
  input wire logic bi_on,
  input wire logic pulse_on,
  input wire logic [7:0] sensors,
  input wire logic [3:0] units,
  // Arc card pins.
  output logic [3:0] light_pin,
  output logic arc_bi_pin,
  output logic [7:0] sensor_seen_pin,
  output logic [3:0] unit_seen_pin
);
  logic [7:0] gap;

  // Counts the interval between wiring test pulses.
  always_ff @(posedge clock) begin
    if (!nrst || gap == 8'(PULSE_GAP - 1)) begin
      gap <= 8'h00;
    end else begin
      gap <= gap + 8'h01;
    end
  end

  assign light_pin = light_on;
  // A wiring test pulse lasts two cycles, far shorter than a real input.
  assign arc_bi_pin = bi_on | (pulse_on & (gap < 8'h02));
  assign sensor_seen_pin = sensors;
  assign unit_seen_pin = units;
endmodule

`default_nettype wire

// >>> verif/afz_trip_logic_tb.sv
`include "afz_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module afz_trip_logic_tb;
  import afz_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic [3:0] light_on = 4'h0;
  logic bi_on = 1'b0;
  logic pulse_on = 1'b0;
  logic [7:0] sensors = 8'h00;
  logic [3:0] units = 4'h0;
  logic [3:0] light_pin, unit_seen_pin;
  logic arc_bi_pin;
  logic [7:0] sensor_seen_pin;
  logic [15:0] ph_b = 16'h0000;
  logic [15:0] res_two = 16'h0000;
  logic block_phase = 1'b0;
  logic block_residual = 1'b0;
  logic [3:0] block_zone = 4'h0;
  logic [3:0] light_detected, zone_trip, zone_blocked, sensor_fault;
  logic arc_binary_input_1, phase_start, residual_start, phase_blocked, residual_blocked;
  logic unit_fault, fast_output_1, fast_output_2;
  int err_total = 0;
  int checks = 0;
  int n;
  logic [3:0] ra [5] = '{`AFZ_REG_CTRL, `AFZ_REG_SENSOR_CFG, `AFZ_REG_PH_LIMIT,
    `AFZ_REG_SAMPLE_REQ, 4'hF};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h78, 32'h1, 32'h0};

  initial begin
    forever #25 clock = ~clock;
  end

  afz_arc_units_model u_afz_arc_units_model (.clock(clock), .nrst(nrst), .light_on(light_on),
    .bi_on(bi_on), .pulse_on(pulse_on), .sensors(sensors), .units(units),
    .light_pin(light_pin), .arc_bi_pin(arc_bi_pin), .sensor_seen_pin(sensor_seen_pin),
    .unit_seen_pin(unit_seen_pin));

  afz_trip_logic #(.TICK_CYCLES(20), .BI_FILTER_CYCLES(8)) u_afz_trip_logic (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .light_pin(light_pin),
    .arc_bi_pin(arc_bi_pin), .sensor_seen_pin(sensor_seen_pin),
    .unit_seen_pin(unit_seen_pin), .phase_current_a(16'h0000), .phase_current_b(ph_b),
    .phase_current_c(16'h0000), .residual_input_one(16'h0000), .residual_input_two(res_two),
    .block_phase(block_phase), .block_residual(block_residual), .block_zone(block_zone),
    .light_detected(light_detected), .arc_binary_input_1(arc_binary_input_1),
    .phase_start(phase_start), .residual_start(residual_start),
    .phase_blocked(phase_blocked), .residual_blocked(residual_blocked),
    .zone_trip(zone_trip), .zone_blocked(zone_blocked), .sensor_fault(sensor_fault),
    .unit_fault(unit_fault), .fast_output_1(fast_output_1), .fast_output_2(fast_output_2));

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic count_bi(input int k);
    n = 0;
    repeat (k) begin
      cyc(1);
      if (arc_binary_input_1 === 1'b1) begin
        n++;
      end
    end
  endtask

  initial begin
    cyc(100000);
    err_total++;
    results();
  end

  initial begin
    cyc(4);
    chk("trip in reset", {28'h0, zone_trip}, 32'h0);
    @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d);
      chk("reset value", d, rv[i]);
    end
    wr(`AFZ_REG_STATUS, 32'hFFFFFFFF);
    rd(`AFZ_REG_STATUS, d);
    chk("status quiet", d, 32'h0);
    $display("test reset done");

    light_on <= 4'h5;
    cyc(5);
    chk("light", {28'h0, light_detected}, 32'h5);
    wr(`AFZ_REG_ZONE_LIGHT, 32'h8924);
    cyc(4);
    chk("disabled zones", {28'h0, zone_trip}, 32'h0);
    wr(`AFZ_REG_CTRL, 32'hF);
    cyc(4);
    chk("zone trip", {28'h0, zone_trip}, 32'h5);
    chk("fast trip", {31'h0, fast_output_1}, 32'h1);
    block_zone <= 4'h1;
    cyc(4);
    chk("trip blocked", {28'h0, zone_trip}, 32'h4);
    chk("zone blocked", {28'h0, zone_blocked}, 32'h1);
    rd(`AFZ_REG_STATUS, d);
    chk("status", d, 32'h1405);
    block_zone <= 4'h0;
    $display("test light done");

    wr(`AFZ_REG_SAMPLE_REQ, 32'h3);
    wr(`AFZ_REG_ZONE_CURR, 32'h1);
    cyc(4);
    chk("no current", {28'h0, zone_trip}, 32'h4);
    ph_b <= 16'h0079;
    cyc(30);
    chk("too few samples", {31'h0, phase_start}, 32'h0);
    cyc(60);
    chk("phase start", {31'h0, phase_start}, 32'h1);
    chk("fast start", {31'h0, fast_output_2}, 32'h1);
    chk("current trip", {28'h0, zone_trip}, 32'h5);
    wr(`AFZ_REG_PH_LIMIT, 32'h79);
    cyc(30);
    chk("at limit", {31'h0, phase_start}, 32'h0);
    wr(`AFZ_REG_PH_LIMIT, 32'h78);
    cyc(80);
    block_phase <= 1'b1;
    cyc(4);
    chk("phase blocked", {30'h0, phase_blocked, phase_start}, 32'h2);
    chk("blocked current", {28'h0, zone_trip}, 32'h4);
    block_phase <= 1'b0;
    $display("test phase done");

    wr(`AFZ_REG_ZONE_CURR, 32'h41);
    res_two <= 16'h0200;
    for (int s = 0; s < 3; s++) begin
      wr(`AFZ_REG_CTRL, 32'(s << 5) | 32'hF);
      cyc(80);
      chk("residual start", {31'h0, residual_start}, 32'(s == 2));
      chk("residual zone", {28'h0, zone_trip}, 32'(s == 2) * 32'h4 + 32'h1);
    end
    block_residual <= 1'b1;
    cyc(4);
    chk("res blocked", {30'h0, residual_blocked, residual_start}, 32'h2);
    $display("test residual done");

    sensors <= 8'h0C;
    cyc(6);
    chk("sensor fault", {28'h0, sensor_fault}, 32'h2);
    wr(`AFZ_REG_SENSOR_CFG, 32'h20C);
    cyc(6);
    chk("sensor ok", {28'h0, sensor_fault}, 32'h0);
    chk("unit fault", {31'h0, unit_fault}, 32'h1);
    units <= 4'h2;
    cyc(6);
    chk("unit ok", {31'h0, unit_fault}, 32'h0);
    $display("test faults done");

    pulse_on <= 1'b1;
    count_bi(100);
    chk("pulses pass", 32'(n != 0), 32'h1);
    wr(`AFZ_REG_CTRL, 32'h1F);
    // Lets a pulse already passed before the filter was switched on die away.
    cyc(8);
    count_bi(100);
    chk("pulses filtered", 32'(n), 32'h0);
    bi_on <= 1'b1;
    cyc(16);
    chk("input held", {31'h0, arc_binary_input_1}, 32'h1);
    $display("test binary input done");
    results();
  end
endmodule

`default_nettype wire
